// >>> logic/wdt_pkg.sv
// constants and types shared by the watchdog design
package wdt_pkg;
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS = 50;
    // tick unit in milliseconds for each unit-select setting
    localparam int unsigned UNIT_SEC_MS   = 1000;
    localparam int unsigned UNIT_MIN_MS   = 60000;
    localparam int unsigned SEC_CYCLES    = (UNIT_SEC_MS * (CLK_HZ / 1000));
    localparam int unsigned MIN_CYCLES    = (UNIT_MIN_MS * (CLK_HZ / 1000));
    localparam int unsigned COUNT_W       = 8;
    localparam logic [7:0]  COUNT_RESET   = 8'h00;
    localparam logic [7:0]  SUBFN_LOAD    = 8'h02;
    localparam logic [7:0]  SERVICE_CODE  = 8'h6F;
    localparam int unsigned PRESCALE_W    = 32;
    typedef enum logic [2:0] {
        ST_OFF    = 3'b001,
        ST_RUN    = 3'b010,
        ST_EXPIRE = 3'b100
    } wdt_state_t;
    typedef enum logic {
        ACT_RESET = 1'b0,
        ACT_NMI   = 1'b1
    } wdt_action_t;
endpackage : wdt_pkg

// >>> logic/wdt_tick_gen.sv
// divider producing a one-cycle tick per selected time unit
module wdt_tick_gen
    import wdt_pkg::*;
#(
    parameter int unsigned SEC_DIV = SEC_CYCLES,
    parameter int unsigned MIN_DIV = MIN_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // control
    input  wire logic run,
    input  wire logic unitMinutes,
    // tick output
    output logic      tick
);
    logic [PRESCALE_W-1:0] div_r;
    logic [PRESCALE_W-1:0] div_nxt;
    logic [PRESCALE_W-1:0] limit;
    logic                  tick_nxt;

    always_comb begin
        limit = unitMinutes ? PRESCALE_W'(MIN_DIV - 1)
                            : PRESCALE_W'(SEC_DIV - 1);
        tick_nxt = 1'b0;
        div_nxt  = div_r + PRESCALE_W'(1);
        // stopped divider restarts a full unit on the next load
        if (!run) begin
            div_nxt = '0;
        end else if (div_r >= limit) begin
            div_nxt  = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_r <= '0;
            tick  <= 1'b0;
        end else begin
            div_r <= div_nxt;
            tick  <= tick_nxt;
        end
    end
endmodule // wdt_tick_gen

// >>> logic/board_watchdog_timer.sv
// watchdog countdown with reset or nmi action on expiry
// Functional notes
// [RULE_01] software loads count through service call
// [RULE_02] nonzero load starts the countdown
// [RULE_03] reaching zero signals an expiry event
// [RULE_04] expiry gives cold reset or nmi
// [RULE_05] each reload restarts from new value
// [RULE_06] zero load disables the watchdog
// [RULE_07] unit-select setting sets tick length
// [RULE_08] software keeps ten percent margin
// [RULE_09] software disables before program exit
// [RULE_10] eight-bit count, one per tick
// [RULE_11] disabled after system reset
module board_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int unsigned SEC_DIV = SEC_CYCLES,
    parameter int unsigned MIN_DIV = MIN_CYCLES,
    parameter int unsigned PULSE_CYCLES = 16
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // load from the service-call handler, same clock domain
    input  wire logic               loadStrobe,
    input  wire logic [COUNT_W-1:0] loadValue,
    // setup options, static levels from the setup store
    input  wire logic               unitMinutes,
    input  wire logic               actionNmi,
    // expiry actions
    output logic                    coldReset,
    output logic                    nmiOut,
    output logic                    expired,
    // status
    output logic                    running,
    output logic [COUNT_W-1:0]      countValue
);
    wdt_state_t         state_r;
    wdt_state_t         state_nxt;
    logic [COUNT_W-1:0] count_r;
    logic [COUNT_W-1:0] count_nxt;
    logic [7:0]         pulse_r;
    logic [7:0]         pulse_nxt;
    logic               coldReset_nxt;
    logic               nmi_nxt;
    logic               expired_nxt;
    logic               tick;
    logic               unitSync1_r;
    logic               unitSync2_r;
    logic               actSync1_r;
    logic               actSync2_r;
    logic [8:0]         actLen_r;
    logic [8:0]         actLen_nxt;

    // setup straps may change asynchronously; two flops before use
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            unitSync1_r <= 1'b0;
            unitSync2_r <= 1'b0;
            actSync1_r  <= 1'b0;
            actSync2_r  <= 1'b0;
        end else begin
            unitSync1_r <= unitMinutes;
            unitSync2_r <= unitSync1_r;
            actSync1_r  <= actionNmi;
            actSync2_r  <= actSync1_r;
        end
    end

    // [RULE_07] unit selects divider
    wdt_tick_gen #(
        .SEC_DIV (SEC_DIV),
        .MIN_DIV (MIN_DIV)
    ) u_tick (
        .clk         (clk),
        .resetn      (resetn),
        .run         (state_r == ST_RUN && !loadStrobe),
        .unitMinutes (unitSync2_r),
        .tick        (tick)
    );

    always_comb begin
        state_nxt     = state_r;
        count_nxt     = count_r;
        pulse_nxt     = pulse_r;
        coldReset_nxt = 1'b0;
        nmi_nxt       = 1'b0;
        expired_nxt   = 1'b0;
        case (state_r)
            ST_OFF, ST_RUN: begin
                if (loadStrobe) begin
                    // [RULE_02] [RULE_05] [RULE_06] load or disable
                    count_nxt = loadValue;
                    state_nxt = (loadValue == '0) ? ST_OFF : ST_RUN;
                end else if (state_r == ST_RUN && tick) begin
                    // [RULE_10] one count per tick
                    count_nxt = count_r - COUNT_W'(1);
                    if (count_r == COUNT_W'(1)) begin
                        // [RULE_03] expiry event
                        state_nxt   = ST_EXPIRE;
                        expired_nxt = 1'b1;
                        // full count: action lags state by one cycle
                        pulse_nxt   = 8'(PULSE_CYCLES);
                    end
                end
            end
            ST_EXPIRE: begin
                // [RULE_04] hold chosen action for a pulse
                coldReset_nxt = !actSync2_r;
                nmi_nxt       = actSync2_r;
                if (pulse_r == 8'h00) begin
                    state_nxt     = ST_OFF;
                    coldReset_nxt = 1'b0;
                    nmi_nxt       = 1'b0;
                end else begin
                    pulse_nxt = pulse_r - 8'h01;
                end
            end
            default: begin
                state_nxt = ST_OFF;
                count_nxt = COUNT_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // [RULE_11] come up disabled
            state_r   <= ST_OFF;
            count_r   <= COUNT_RESET;
            pulse_r   <= 8'h00;
            coldReset <= 1'b0;
            nmiOut    <= 1'b0;
            expired   <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            count_r   <= count_nxt;
            pulse_r   <= pulse_nxt;
            coldReset <= coldReset_nxt;
            nmiOut    <= nmi_nxt;
            expired   <= expired_nxt;
        end
    end

    assign running    = (state_r == ST_RUN);
    assign countValue = count_r;

    // checker helper: cycles the current action has stood so far
    always_comb begin
        actLen_nxt = '0;
        if (coldReset || nmiOut) begin
            actLen_nxt = actLen_r + 9'(1);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            actLen_r <= '0;
        end else begin
            actLen_r <= actLen_nxt;
        end
    end

    // [RULE_06] zero load stops the count
    a_zero_disables: assert property ( // [RULE_06]
        @(posedge clk) disable iff (!resetn)
        loadStrobe && loadValue == '0 |=> !running ##1 !expired)
        else $error("zero load did not disable");

    // [RULE_02] nonzero load starts run
    a_load_starts: assert property ( // [RULE_02]
        @(posedge clk) disable iff (!resetn)
        loadStrobe && loadValue != '0 && state_r != ST_EXPIRE
        |=> running && countValue == $past(loadValue))
        else $error("nonzero load did not start count");

    // [RULE_02] running count never zero
    a_run_nonzero: assert property ( // [RULE_02]
        @(posedge clk) disable iff (!resetn)
        running |-> countValue != 8'h00)
        else $error("running with zero count");

    // [RULE_10] decrement by one per tick
    a_tick_decrement: assert property ( // [RULE_10]
        @(posedge clk) disable iff (!resetn)
        running && tick && !loadStrobe && countValue > 1
        |=> countValue == $past(countValue) - 8'h01)
        else $error("count did not decrement by one");

    // [RULE_10] no change without tick
    a_count_holds: assert property ( // [RULE_10]
        @(posedge clk) disable iff (!resetn)
        running && !tick && !loadStrobe |=> $stable(countValue))
        else $error("count changed without tick");

    // [RULE_03] last tick expires
    a_expiry_event: assert property ( // [RULE_03]
        @(posedge clk) disable iff (!resetn)
        running && tick && !loadStrobe && countValue == 8'h01
        |=> expired ##1 !expired)
        else $error("expiry pulse missing");

    // [RULE_04] reset action selected
    a_reset_action: assert property ( // [RULE_04]
        @(posedge clk) disable iff (!resetn)
        expired && !actSync2_r && $stable(actSync2_r) |=> coldReset && !nmiOut)
        else $error("cold reset action missing");

    // [RULE_04] nmi action selected
    a_nmi_action: assert property ( // [RULE_04]
        @(posedge clk) disable iff (!resetn)
        expired && actSync2_r && $stable(actSync2_r) |=> nmiOut && !coldReset)
        else $error("nmi action missing");

    // [RULE_04] only one action at once
    a_action_exclusive: assert property ( // [RULE_04]
        @(posedge clk) disable iff (!resetn)
        !(coldReset && nmiOut))
        else $error("both actions driven");

    // [RULE_04] loads dropped during action
    a_load_refused: assert property ( // [RULE_04]
        @(posedge clk) disable iff (!resetn)
        state_r == ST_EXPIRE && loadStrobe |=> !running)
        else $error("load accepted during action");

    // [RULE_06] no action while off
    a_off_quiet: assert property ( // [RULE_06]
        @(posedge clk) disable iff (!resetn)
        state_r == ST_OFF |-> !coldReset && !nmiOut && !expired)
        else $error("action while disabled");

    // [RULE_04] action ends within 300 cycles
    a_action_ends: assert property ( // [RULE_04]
        @(posedge clk) disable iff (!resetn)
        $rose(coldReset || nmiOut) |-> ##[1:300] !(coldReset || nmiOut))
        else $error("action never released");

    // [RULE_04] action lasts the full pulse
    a_pulse_length: assert property ( // [RULE_04]
        @(posedge clk) disable iff (!resetn)
        $fell(coldReset || nmiOut) |-> actLen_r == 9'(PULSE_CYCLES))
        else $error("action pulse length wrong");
endmodule // board_watchdog_timer

// >>> test/board_watchdog_timer_tb_top.sv
// self-checking bench for the watchdog countdown and expiry actions
module board_watchdog_timer_tb_top
    import wdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // short units keep the run brief
    localparam int SDIV  = 10;
    localparam int MDIV  = 20;
    localparam int PULSE = 16;
    logic               clk         = 1'b0;
    logic               resetn      = 1'b0;
    logic               loadStrobe  = 1'b0;
    logic [COUNT_W-1:0] loadValue   = 8'h00;
    logic               unitMinutes = 1'b0;
    logic               actionNmi   = 1'b0;
    logic               coldReset;
    logic               nmiOut;
    logic               expired;
    logic               running;
    logic [COUNT_W-1:0] countValue;
    int                 errors       = 0;
    int                 total_checks = 0;
    int                 cycleCount   = 0;

    board_watchdog_timer #(.SEC_DIV(SDIV), .MIN_DIV(MDIV),
        .PULSE_CYCLES(PULSE)) uut (
        .clk(clk), .resetn(resetn), .loadStrobe(loadStrobe),
        .loadValue(loadValue), .unitMinutes(unitMinutes),
        .actionNmi(actionNmi), .coldReset(coldReset), .nmiOut(nmiOut),
        .expired(expired), .running(running), .countValue(countValue));

    always #25 clk = ~clk;

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // a hung wait must still reach the report
    always @(posedge clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 20000) begin
            errors++;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    // strobe held one cycle, taken at the rising edge in between
    task automatic load(input logic [7:0] v);
        @(negedge clk);
        loadStrobe = 1'b1;
        loadValue  = v;
        @(negedge clk);
        loadStrobe = 1'b0;
    endtask

    task automatic expire(input logic [7:0] n, input int div, input logic nmi);
        int k;
        actionNmi = nmi;
        cycles(4);
        load(n);
        chk("running", 8'h01, {7'h00, running});
        cycles(div / 2);
        chk("count", n, countValue);
        cycles(div);
        chk("count", n - 8'h01, countValue);
        k = div / 2 + div;
        while (expired !== 1'b1 && k < n * div + 10) begin
            cycles(1);
            k++;
        end
        chk("expiry time", 8'h01,
            {7'h00, k >= n * div - 2 && k <= n * div + 2});
        chk("expired", 8'h01, {7'h00, expired});
        chk("count", 8'h00, countValue);
        cycles(1);
        chk("coldReset", {7'h00, !nmi}, {7'h00, coldReset});
        chk("nmiOut", {7'h00, nmi}, {7'h00, nmiOut});
        // a load during the action pulse is dropped
        load(n);
        chk("running", 8'h00, {7'h00, running});
        k = 2;
        while ((coldReset | nmiOut) === 1'b1 && k < 300) begin
            cycles(1);
            k++;
        end
        chk("pulse length", 8'(PULSE), 8'(k));
    endtask

    task automatic t_reset();
        chk("running", 8'h00, {7'h00, running});
        chk("count", 8'h00, countValue);
        chk("actions", 8'h00, {6'h00, coldReset, nmiOut});
    endtask

    task automatic t_reload();
        load(8'hFF);
        cycles(SDIV + 5);
        chk("count", 8'hFE, countValue);
        load(8'h04);
        load(8'h02);
        cycles(SDIV / 2);
        chk("count", 8'h02, countValue);
    endtask

    // refresh every 17 cycles against a 21-cycle time-out
    task automatic t_refresh();
        int seen;
        seen = 0;
        repeat (4) begin
            load(8'h02);
            repeat (SDIV + 5) begin
                cycles(1);
                if ((expired | coldReset | nmiOut) !== 1'b0) seen++;
            end
            chk("count", 8'h01, countValue);
        end
        chk("refreshed", 8'h00, 8'(seen));
        load(8'h00);
    endtask

    task automatic t_disable();
        int seen;
        seen = 0;
        load(8'h05);
        cycles(3);
        load(8'h00);
        chk("running", 8'h00, {7'h00, running});
        chk("count", 8'h00, countValue);
        repeat (8 * SDIV) begin
            cycles(1);
            if ((expired | coldReset | nmiOut) !== 1'b0) seen++;
        end
        chk("silent", 8'h00, 8'(seen));
    endtask

    initial begin
        cycles(10);
        resetn = 1'b1;
        cycles(1);
        t_reset();
        expire(8'h03, SDIV, 1'b0);
        unitMinutes = 1'b1;
        expire(8'h02, MDIV, 1'b1);
        unitMinutes = 1'b0;
        t_reload();
        t_refresh();
        t_disable();
        summarize();
    end
endmodule // board_watchdog_timer_tb_top
